/* power_down_wakeup_pkg.sv */
package power_down_wakeup_pkg;

  // accumulator transfer targets
  typedef enum logic [3:0] {
    SEL_P0_WAKE  = 4'h0,
    SEL_P1_WAKE  = 4'h1,
    SEL_IRQ_WAKE = 4'h2,
    SEL_P0_PULL  = 4'h3,
    SEL_P1_PULL  = 4'h4,
    SEL_IRQ0_CTL = 4'h5,
    SEL_IRQ1_CTL = 4'h6,
    SEL_FMT0     = 4'h7,
    SEL_FMT1     = 4'h8,
    SEL_FMT2     = 4'h9,
    SEL_FMT3     = 4'ha
  } regSel_t;

  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_CLOCK_RUN = 2'b01,
    ST_RETENTION = 2'b10,
    ST_RESTART   = 2'b11
  } pdState_t;

  // one-cycle instruction strobes from the core
  typedef struct packed {
    logic armPowerDown;
    logic clockRunSleep;
    logic retentionSleep;
    logic armStandbyMonitor;
    logic skipIfPowerDown;
    logic store;
    logic load;
    regSel_t sel;
    logic [3:0] acc;
  } cpuOp_t;

  localparam int NUM_REGS = 11;
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [2:0] SP_LEVEL_POWER_DOWN = 3'h7;
  localparam logic [1:0] CNTR_INPUT_SEL = 2'h3;
  localparam logic P_FLAG_WARM = 1'b1;
  localparam logic P_FLAG_COLD = 1'b0;
  // wakeup control for the interrupt pins
  localparam int K2_EXT_IRQ0_PIN_WAKE = 0;
  localparam int K2_EXT_IRQ0_PIN_EDGE = 1;
  localparam int K2_EXT_IRQ1_PIN_WAKE = 2;
  localparam int K2_EXT_IRQ1_PIN_EDGE = 3;
  // external interrupt control fields
  localparam int IRQ_RETURN_LEVEL = 2;
  localparam int IRQ_INPUT_ENABLE = 3;

endpackage

/* power_down_wakeup_control.sv */
`timescale 1ns/10ps
`default_nettype none

module power_down_wakeup_control
  import power_down_wakeup_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // core instruction strobes
  input wire cpuOp_t cpuOp,
  output logic [3:0] accOut,
  output logic accValid,
  output logic skipTaken,
  // core restart and init
  output logic cpuInitPulse,
  output logic flagInitPulse,
  output logic [2:0] spLoadValue,
  output logic restartPulse,
  output logic powerDownFlag,
  output logic wakeByTimer5,
  // reset sources
  input wire logic supplyMonitorEnablePin,
  input wire logic supplyLow,
  input wire logic resetPinReq,
  input wire logic watchdogReq,
  output logic detEnable,
  output logic systemReset,
  // wakeup sources
  input wire logic [3:0] port0Pins,
  input wire logic [3:0] port1Pins,
  input wire logic extIrq0Pin,
  input wire logic extIrq1Pin,
  input wire logic timer5Flag,
  // control register views
  output logic [3:0] port0Pullup,
  output logic [3:0] port1Pullup,
  output logic [3:0] extIrq0Ctrl,
  output logic [3:0] extIrq1Ctrl,
  output logic [15:0] portFormat,
  // clock and peripheral gating
  output logic mainClockStop,
  output logic subClockStop,
  output logic lcdOff,
  output logic timer5Run,
  output logic portHold,
  // counter-1 / port C pin
  input wire logic [1:0] counter1Select,
  input wire logic portCLevel,
  output logic counter1PinOut,
  output logic counter1PinOe
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  pdState_t state;
  pdState_t next_state;
  logic [3:0] ctrlReg [NUM_REGS];
  logic pdArmed;
  logic standbyArmed;
  logic prevIrq0;
  logic prevIrq1;
  logic coldEvent;
  logic portWake;
  logic irq0Wake;
  logic irq1Wake;
  logic extWake;
  logic inPowerDown;
  logic entering;
  logic selValid;

  // return condition of one interrupt pin
  function automatic logic irqWake(
    input logic pin,
    input logic prev,
    input logic wakeEn,
    input logic edgeMode,
    input logic [3:0] ctrl
  );
    logic lvl;
    logic hit;
    lvl = ctrl[IRQ_RETURN_LEVEL];
    hit = edgeMode ? ((pin == lvl) && (prev != lvl)) : (pin == lvl);
    return wakeEn && ctrl[IRQ_INPUT_ENABLE] && hit;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // reset sources and wake decode

  assign coldEvent = resetPinReq || watchdogReq || (detEnable && supplyLow);
  assign selValid = (int'(cpuOp.sel) < NUM_REGS);
  assign inPowerDown = (state == ST_CLOCK_RUN) || (state == ST_RETENTION);

  assign portWake = |(ctrlReg[SEL_P0_WAKE] & ~port0Pins)
                 || |(ctrlReg[SEL_P1_WAKE] & ~port1Pins);
  assign irq0Wake = irqWake(extIrq0Pin, prevIrq0,
                            ctrlReg[SEL_IRQ_WAKE][K2_EXT_IRQ0_PIN_WAKE],
                            ctrlReg[SEL_IRQ_WAKE][K2_EXT_IRQ0_PIN_EDGE],
                            ctrlReg[SEL_IRQ0_CTL]);
  assign irq1Wake = irqWake(extIrq1Pin, prevIrq1,
                            ctrlReg[SEL_IRQ_WAKE][K2_EXT_IRQ1_PIN_WAKE],
                            ctrlReg[SEL_IRQ_WAKE][K2_EXT_IRQ1_PIN_EDGE],
                            ctrlReg[SEL_IRQ1_CTL]);
  assign extWake = portWake || irq0Wake || irq1Wake;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prevIrq0 <= 1'b0;
      prevIrq1 <= 1'b0;
    end else begin
      prevIrq0 <= extIrq0Pin;
      prevIrq1 <= extIrq1Pin;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power-down sequencing

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (pdArmed && cpuOp.clockRunSleep) begin
          next_state = ST_CLOCK_RUN;
        end else if (pdArmed && cpuOp.retentionSleep) begin
          next_state = ST_RETENTION;
        end
      end
      ST_CLOCK_RUN: begin
        if (extWake || timer5Flag) begin
          next_state = ST_RESTART;
        end
      end
      ST_RETENTION: begin
        if (extWake) begin
          next_state = ST_RESTART;
        end
      end
      ST_RESTART: begin
        next_state = ST_RUN;
      end
    endcase
    if (coldEvent) begin
      next_state = ST_RUN;
    end
  end

  assign entering = (state == ST_RUN)
                 && ((next_state == ST_CLOCK_RUN) || (next_state == ST_RETENTION));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // arm is consumed by entry; a bare sleep leaves state in run
  always_ff @(posedge mclk) begin
    if (!rst_n || coldEvent) begin
      pdArmed <= 1'b0;
    end else if (entering) begin
      pdArmed <= 1'b0;
    end else if (cpuOp.armPowerDown) begin
      pdArmed <= 1'b1;
    end
  end

  // standby arm stays set once taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      standbyArmed <= 1'b0;
    end else if (cpuOp.armStandbyMonitor) begin
      standbyArmed <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      detEnable <= 1'b0;
    end else if (inPowerDown) begin
      detEnable <= supplyMonitorEnablePin && standbyArmed;
    end else begin
      detEnable <= supplyMonitorEnablePin;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      systemReset <= 1'b0;
    end else begin
      systemReset <= coldEvent;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags and restart

  always_ff @(posedge mclk) begin
    if (!rst_n || coldEvent) begin
      powerDownFlag <= P_FLAG_COLD;
    end else if (entering) begin
      powerDownFlag <= P_FLAG_WARM;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || coldEvent) begin
      wakeByTimer5 <= 1'b0;
    end else if (entering) begin
      wakeByTimer5 <= 1'b0;
    end else if (state == ST_CLOCK_RUN && next_state == ST_RESTART) begin
      wakeByTimer5 <= timer5Flag && !extWake;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      restartPulse <= 1'b0;
      cpuInitPulse <= 1'b0;
      flagInitPulse <= 1'b0;
      spLoadValue <= SP_LEVEL_POWER_DOWN;
    end else begin
      restartPulse <= (next_state == ST_RESTART);
      cpuInitPulse <= entering;
      flagInitPulse <= entering;
      if (entering) begin
        spLoadValue <= SP_LEVEL_POWER_DOWN;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      skipTaken <= 1'b0;
    end else begin
      skipTaken <= cpuOp.skipIfPowerDown && powerDownFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers, untouched by power-down entry

  always_ff @(posedge mclk) begin
    if (!rst_n || coldEvent) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        ctrlReg[i] <= REG_RESET;
      end
    end else if (cpuOp.store && selValid) begin
      ctrlReg[cpuOp.sel] <= cpuOp.acc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accOut <= REG_RESET;
      accValid <= 1'b0;
    end else begin
      accValid <= cpuOp.load;
      if (cpuOp.load) begin
        accOut <= selValid ? ctrlReg[cpuOp.sel] : REG_RESET;
      end
    end
  end

  assign port0Pullup = ctrlReg[SEL_P0_PULL];
  assign port1Pullup = ctrlReg[SEL_P1_PULL];
  assign extIrq0Ctrl = ctrlReg[SEL_IRQ0_CTL];
  assign extIrq1Ctrl = ctrlReg[SEL_IRQ1_CTL];
  assign portFormat = {ctrlReg[SEL_FMT3], ctrlReg[SEL_FMT2],
                       ctrlReg[SEL_FMT1], ctrlReg[SEL_FMT0]};

  ////////////////////////////////////////////////////////////////////
  // clock, peripheral and pin gating

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mainClockStop <= 1'b0;
      subClockStop <= 1'b0;
      lcdOff <= 1'b0;
      timer5Run <= 1'b1;
      portHold <= 1'b0;
    end else begin
      mainClockStop <= (next_state == ST_CLOCK_RUN) || (next_state == ST_RETENTION);
      subClockStop <= (next_state == ST_RETENTION);
      lcdOff <= (next_state == ST_RETENTION);
      timer5Run <= (next_state != ST_RETENTION);
      portHold <= (next_state == ST_CLOCK_RUN) || (next_state == ST_RETENTION);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      counter1PinOut <= 1'b0;
      counter1PinOe <= 1'b1;
    end else begin
      counter1PinOe <= (counter1Select != CNTR_INPUT_SEL);
      counter1PinOut <= inPowerDown ? 1'b0 : portCLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  det_drop_reset_a: assert property (
    (detEnable && supplyLow) |=> (systemReset && state == ST_RUN && !powerDownFlag))
    else $error("supply drop did not reset");
  det_run_pin_a: assert property (
    (state == ST_RUN) |=> (detEnable == $past(supplyMonitorEnablePin)))
    else $error("run detector enable wrong");
  det_standby_gate_a: assert property (
    inPowerDown |=> (detEnable == $past(supplyMonitorEnablePin && standbyArmed)))
    else $error("power-down detector enable wrong");
  standby_latch_hold_a: assert property (
    standbyArmed |=> standbyArmed)
    else $error("standby arm latch dropped");
  // gating checked on the entry cycle; an immediate wake may drop it one cycle on
  sleep_entry_a: assert property (
    (state == ST_RUN && pdArmed && cpuOp.clockRunSleep && !coldEvent)
      |=> (state == ST_CLOCK_RUN && mainClockStop && !subClockStop))
    else $error("clock mode entry failed");
  sleep_nop_a: assert property (
    (state == ST_RUN && !pdArmed) |=> (state == ST_RUN))
    else $error("unarmed sleep entered power-down");
  entry_init_a: assert property (
    entering |=> (flagInitPulse && cpuInitPulse && spLoadValue == 3'h7) ##1 !cpuInitPulse)
    else $error("entry initialization missing");
  cntr_pin_low_a: assert property (
    (inPowerDown && counter1Select != CNTR_INPUT_SEL)
      |=> (counter1PinOe && !counter1PinOut))
    else $error("counter pin not low in power-down");
  timer5_return_a: assert property (
    (state == ST_CLOCK_RUN && timer5Flag && !coldEvent) |=> (state == ST_RESTART))
    else $error("timer 5 flag did not wake");
  retention_hold_a: assert property (
    (state == ST_RETENTION && !extWake && !coldEvent) |=> (state == ST_RETENTION))
    else $error("RAM back-up left without wakeup");
  warm_restart_a: assert property (
    (state == ST_RESTART) |-> (restartPulse && powerDownFlag) ##1 (state == ST_RUN))
    else $error("warm restart wrong");
  cold_flag_a: assert property (
    coldEvent |=> (!powerDownFlag && systemReset))
    else $error("cold start kept power-down flag");
  reset_clears_a: assert property (
    coldEvent |=> (port0Pullup == 4'h0 && port1Pullup == 4'h0 && portFormat == 16'h0))
    else $error("control registers not cleared");
  retention_lcd_a: assert property (
    (state == ST_RETENTION) |-> (lcdOff && subClockStop && !timer5Run))
    else $error("RAM back-up gating wrong");

  wake_timer5_c: cover property (
    (state == ST_CLOCK_RUN) ##1 (state == ST_RESTART) ##1 wakeByTimer5);
  wake_pin_c: cover property (
    (state == ST_RETENTION && portWake) ##1 (state == ST_RESTART));
  sleep_nop_c: cover property (
    (state == ST_RUN && !pdArmed && cpuOp.retentionSleep) ##1 (state == ST_RUN));
  supply_reset_c: cover property (
    inPowerDown && detEnable && supplyLow);

endmodule

`default_nettype wire

/* core_side_model.sv */
`timescale 1ns/10ps
`default_nettype none

module core_side_model
  import power_down_wakeup_pkg::*;
(
  // clock
  input wire logic mclk,
  // instruction strobes
  output var cpuOp_t cpuOp
);

  initial begin
    cpuOp = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe lives one cycle; data lines scrambled once released
  task automatic issue(input cpuOp_t op);
    cpuOp_t idle;
    idle = '0;
    idle.acc = ~op.acc;
    @(posedge mclk);
    cpuOp <= op;
    @(posedge mclk);
    cpuOp <= idle;
  endtask

  task automatic store(input regSel_t s, input logic [3:0] v);
    cpuOp_t op;
    op = '0;
    op.store = 1'b1;
    op.sel = s;
    op.acc = v;
    issue(op);
  endtask

  task automatic load(input regSel_t s);
    cpuOp_t op;
    op = '0;
    op.load = 1'b1;
    op.sel = s;
    issue(op);
  endtask

  // 0 arm, 1 clock-run sleep, 2 retention sleep, 3 standby arm, 4 skip
  task automatic ins(input int k);
    cpuOp_t op;
    op = '0;
    case (k)
      0: op.armPowerDown = 1'b1;
      1: op.clockRunSleep = 1'b1;
      2: op.retentionSleep = 1'b1;
      3: op.armStandbyMonitor = 1'b1;
      default: op.skipIfPowerDown = 1'b1;
    endcase
    issue(op);
  endtask

  // watchdog restart would go first; it has no port on this block
  task automatic powerDown(input logic retention);
    ins(0);
    ins(retention ? 2 : 1);
  endtask

endmodule

`default_nettype wire

/* tb_power_down_wakeup_control.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_power_down_wakeup_control
  import power_down_wakeup_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  cpuOp_t cpuOp;
  logic [3:0] accOut, port0Pullup, port1Pullup, extIrq0Ctrl, extIrq1Ctrl;
  logic accValid, skipTaken, cpuInitPulse, flagInitPulse, restartPulse;
  logic powerDownFlag, wakeByTimer5, detEnable, systemReset, mainClockStop;
  logic subClockStop, lcdOff, timer5Run, portHold, counter1PinOut, counter1PinOe;
  logic [2:0] spLoadValue;
  logic [15:0] portFormat;
  logic supplyMonitorEnablePin = 1'b1;
  logic supplyLow = 1'b0;
  logic resetPinReq = 1'b0;
  logic watchdogReq = 1'b0;
  logic extIrq0Pin = 1'b0;
  logic extIrq1Pin = 1'b0;
  logic timer5Flag = 1'b0;
  logic portCLevel = 1'b1;
  logic [3:0] port0Pins = 4'hf;
  logic [3:0] port1Pins = 4'hf;
  logic [1:0] counter1Select = 2'h0;
  int badCount = 0;
  int samplesChecked = 0;
  int i;

  always #2.5 mclk = ~mclk;

  power_down_wakeup_control dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .cpuOp(cpuOp),
    .accOut(accOut),
    .accValid(accValid),
    .skipTaken(skipTaken),
    .cpuInitPulse(cpuInitPulse),
    .flagInitPulse(flagInitPulse),
    .spLoadValue(spLoadValue),
    .restartPulse(restartPulse),
    .powerDownFlag(powerDownFlag),
    .wakeByTimer5(wakeByTimer5),
    .supplyMonitorEnablePin(supplyMonitorEnablePin),
    .supplyLow(supplyLow),
    .resetPinReq(resetPinReq),
    .watchdogReq(watchdogReq),
    .detEnable(detEnable),
    .systemReset(systemReset),
    .port0Pins(port0Pins),
    .port1Pins(port1Pins),
    .extIrq0Pin(extIrq0Pin),
    .extIrq1Pin(extIrq1Pin),
    .timer5Flag(timer5Flag),
    .port0Pullup(port0Pullup),
    .port1Pullup(port1Pullup),
    .extIrq0Ctrl(extIrq0Ctrl),
    .extIrq1Ctrl(extIrq1Ctrl),
    .portFormat(portFormat),
    .mainClockStop(mainClockStop),
    .subClockStop(subClockStop),
    .lcdOff(lcdOff),
    .timer5Run(timer5Run),
    .portHold(portHold),
    .counter1Select(counter1Select),
    .portCLevel(portCLevel),
    .counter1PinOut(counter1PinOut),
    .counter1PinOe(counter1PinOe)
  );
  core_side_model core (.mclk(mclk), .cpuOp(cpuOp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic printVerdict();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return restartPulse;
      1: return cpuInitPulse;
      default: return systemReset;
    endcase
  endfunction

  // bounded wait for a pulse: 0 restart, 1 entry, 2 system reset
  task automatic waitFor(input int w, input int n);
    for (int k = 0; k < n && pick(w) !== 1'b1; k++) begin
      step();
    end
    chk(pick(w), 1'b1);
  endtask

  task automatic quiet(input int w, input int n);
    repeat (n) begin
      step();
      chk(pick(w), 1'b0);
    end
  endtask

  task automatic enter(input logic retention);
    core.powerDown(retention);
    #1;
    waitFor(1, 3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    step();
    step();
    chk(powerDownFlag, 1'b0);
    chk(timer5Run, 1'b1);
    chk(detEnable, 1'b1);
    chk({counter1PinOut, counter1PinOe}, 2'b11);
    for (i = 0; i < 12; i++) begin
      core.load(regSel_t'(i));
      #1;
      chk({accValid, accOut}, 5'h10);
    end
    for (i = 0; i < 12; i++) core.store(regSel_t'(i), 4'(i + 3));
    for (i = 0; i < 12; i++) begin
      core.load(regSel_t'(i));
      #1;
      chk(accOut, (i < 11) ? 4'(i + 3) : 4'h0);
    end
    chk({port1Pullup, port0Pullup}, 8'h76);
    chk({extIrq1Ctrl, extIrq0Ctrl}, 8'h98);
    chk(portFormat, 16'hdcba);
    core.store(SEL_P0_WAKE, 4'h2);
    core.store(SEL_P1_WAKE, 4'h0);
    core.store(SEL_IRQ_WAKE, 4'h0);
    // sleep without arm
    core.ins(1);
    core.ins(2);
    quiet(1, 3);
    chk({powerDownFlag, mainClockStop}, 2'b00);
    // clock-run mode, timer 5 wake
    enter(1'b0);
    chk({flagInitPulse, powerDownFlag}, 2'b11);
    chk(spLoadValue, 3'h7);
    step();
    chk({mainClockStop, portHold, lcdOff, subClockStop, timer5Run}, 5'b11001);
    chk({counter1PinOut, counter1PinOe}, 2'b01);
    chk(detEnable, 1'b0);
    @(posedge mclk);
    timer5Flag <= 1'b1;
    #1;
    waitFor(0, 4);
    chk(powerDownFlag, 1'b1);
    step();
    chk({wakeByTimer5, mainClockStop}, 2'b10);
    @(posedge mclk);
    timer5Flag <= 1'b0;
    core.ins(4);
    #1;
    chk(skipTaken, 1'b1);
    // retention: timer flag refused, enabled port 0 pin wakes
    @(posedge mclk);
    counter1Select <= 2'h3;
    enter(1'b1);
    step();
    chk({lcdOff, subClockStop, mainClockStop}, 3'b111);
    chk(counter1PinOe, 1'b0);
    @(posedge mclk);
    timer5Flag <= 1'b1;
    port0Pins <= 4'h2;
    port1Pins <= 4'h0;
    quiet(0, 5);
    @(posedge mclk);
    port0Pins <= 4'h0;
    timer5Flag <= 1'b0;
    #1;
    waitFor(0, 4);
    @(posedge mclk);
    port0Pins <= 4'hf;
    port1Pins <= 4'hf;
    // flag already set on entry
    timer5Flag <= 1'b1;
    enter(1'b0);
    waitFor(0, 3);
    @(posedge mclk);
    timer5Flag <= 1'b0;
    // interrupt pin level wake
    core.store(SEL_IRQ_WAKE, 4'h1);
    core.store(SEL_IRQ0_CTL, 4'hc);
    enter(1'b1);
    quiet(0, 3);
    @(posedge mclk);
    extIrq0Pin <= 1'b1;
    #1;
    waitFor(0, 4);
    // interrupt pin edge wake: steady high refused, rising edge wakes
    @(posedge mclk);
    extIrq0Pin <= 1'b0;
    extIrq1Pin <= 1'b1;
    core.store(SEL_IRQ_WAKE, 4'hc);
    core.store(SEL_IRQ1_CTL, 4'hc);
    enter(1'b1);
    quiet(0, 3);
    @(posedge mclk);
    extIrq1Pin <= 1'b0;
    quiet(0, 2);
    @(posedge mclk);
    extIrq1Pin <= 1'b1;
    #1;
    waitFor(0, 4);
    // detector gating: pin drops one cycle before the low supply
    @(posedge mclk);
    supplyMonitorEnablePin <= 1'b0;
    @(posedge mclk);
    supplyLow <= 1'b1;
    quiet(2, 3);
    chk(detEnable, 1'b0);
    @(posedge mclk);
    supplyMonitorEnablePin <= 1'b1;
    supplyLow <= 1'b0;
    core.ins(3);
    core.ins(3);
    enter(1'b0);
    step();
    step();
    chk(detEnable, 1'b1);
    @(posedge mclk);
    supplyLow <= 1'b1;
    #1;
    waitFor(2, 3);
    chk({powerDownFlag, mainClockStop, port0Pullup}, 6'h00);
    @(posedge mclk);
    supplyLow <= 1'b0;
    core.ins(4);
    #1;
    chk(skipTaken, 1'b0);
    // pin and watchdog resets
    for (i = 0; i < 2; i++) begin
      core.store(SEL_P1_PULL, 4'h5);
      enter(1'b0);
      @(posedge mclk);
      resetPinReq <= (i == 0);
      watchdogReq <= (i == 1);
      #1;
      waitFor(2, 3);
      chk({powerDownFlag, port1Pullup}, 5'h00);
      @(posedge mclk);
      resetPinReq <= 1'b0;
      watchdogReq <= 1'b0;
      step();
    end
    printVerdict();
  end

  initial begin
    #100000;
    badCount++;
    printVerdict();
  end

endmodule

`default_nettype wire
